// >>> rtl/arp_acl_field_matcher.sv
`default_nettype none
module arp_acl_field_matcher
  import arp_acl_pkg::*;
#(
  parameter int CNT_W = 32
)
(
  input wire logic core_clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // parsed frame and result
  input wire arp_fields_t fields,
  output logic arp_match,
  output logic entry_hit,
  output logic frame_drop
);

  // counter must fit in the data word and be able to count
  if (CNT_W < 1 || CNT_W > 32)
  begin : g_cnt_check
    $error("CNT_W must be 1 to 32");
  end

  entry_cfg_t ctrl_r;
  logic [31:0] sip_addr_r;
  logic [31:0] sender_proto_mask_cfg_r;
  logic [31:0] tip_addr_r;
  logic [31:0] tip_mask_r;
  logic [CNT_W-1:0] hit_cnt_r;
  logic last_hit_r;
  logic last_drop_r;
  logic ack_r;
  logic wr_take;

  // merge write data into a register under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // host or masked network compare of a protocol address
  function automatic logic addr_pass(input logic [1:0] mode, input logic [31:0] frame_addr,
                                     input logic [31:0] cfg_addr, input logic [31:0] cfg_mask);
    logic res;
    res = 1'b1;
    case (mode)
      ADDR_HOST: res = (frame_addr == cfg_addr);
      ADDR_NET: res = ((frame_addr ^ cfg_addr) & cfg_mask) == 32'h0000_0000;
      default: res = 1'b1;
    endcase
    return res;
  endfunction

  // three-way check: 0 needs unequal, 1 needs equal, rest is don't-care
  function automatic logic tri_pass(input logic [1:0] sel, input logic equal);
    logic res;
    res = 1'b1;
    case (sel)
      TRI_ZERO: res = !equal;
      TRI_ONE: res = equal;
      default: res = 1'b1;
    endcase
    return res;
  endfunction

  // one wait cycle per access; slave answers on the second edge
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ack_r <= 1'b0;
    end
    else
    begin
      ack_r <= (avs_read || avs_write) && !ack_r;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign wr_take = avs_write && ack_r;

  // configuration registers; software writes steer the match logic
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r <= CTRL_RESET;
      sip_addr_r <= 32'h0000_0000;
      sender_proto_mask_cfg_r <= 32'h0000_0000;
      tip_addr_r <= 32'h0000_0000;
      tip_mask_r <= 32'h0000_0000;
    end
    else if (wr_take)
    begin
      case (avs_address)
        OFS_CTRL: ctrl_r <= be_merge(ctrl_r, avs_writedata, avs_byteenable);
        OFS_SIP_ADDR: sip_addr_r <= be_merge(sip_addr_r, avs_writedata, avs_byteenable);
        OFS_SENDER_PROTO_MASK_CFG: sender_proto_mask_cfg_r <= be_merge(sender_proto_mask_cfg_r, avs_writedata, avs_byteenable);
        OFS_TIP_ADDR: tip_addr_r <= be_merge(tip_addr_r, avs_writedata, avs_byteenable);
        OFS_TIP_MASK: tip_mask_r <= be_merge(tip_mask_r, avs_writedata, avs_byteenable);
        default: ;
      endcase
    end
  end

  // opcode classification
  logic is_arp_op;
  logic is_rarp_op;
  logic is_req_op;
  logic is_reply_op;
  assign is_arp_op = fields.arp_opcode_field == OPC_ARP_REQ || fields.arp_opcode_field == OPC_ARP_REPLY;
  assign is_rarp_op = fields.arp_opcode_field == OPC_RARP_REQ || fields.arp_opcode_field == OPC_RARP_REPLY;
  assign is_req_op = fields.arp_opcode_field == OPC_ARP_REQ || fields.arp_opcode_field == OPC_RARP_REQ;
  assign is_reply_op = fields.arp_opcode_field == OPC_ARP_REPLY || fields.arp_opcode_field == OPC_RARP_REPLY;

  // per-criterion results
  logic kind_ok;
  logic dir_ok;
  logic sip_ok;
  logic tip_ok;
  logic sha_ok;
  logic tha_ok;
  logic len_ok;
  logic hrd_ok;
  logic pro_ok;
  logic all_ok;

  // opcode kind selector
  always_comb
  begin
    case (ctrl_r.kind_sel)
      KIND_ARP: kind_ok = is_arp_op;
      KIND_RARP: kind_ok = is_rarp_op;
      KIND_OTHER: kind_ok = !is_arp_op && !is_rarp_op;
      default: kind_ok = 1'b1;
    endcase
  end

  // direction selector; the unused code behaves as don't-care
  always_comb
  begin
    case (ctrl_r.dir_sel)
      DIR_REQ: dir_ok = is_req_op;
      DIR_REPLY: dir_ok = is_reply_op;
      default: dir_ok = 1'b1;
    endcase
  end

  // protocol address filters, mode any passes through the default arm
  assign sip_ok = addr_pass(ctrl_r.sip_mode, fields.sender_proto_addr, sip_addr_r, sender_proto_mask_cfg_r);
  assign tip_ok = addr_pass(ctrl_r.tip_mode, fields.target_proto_addr, tip_addr_r, tip_mask_r);

  // hardware address consistency with the source mac
  assign sha_ok = tri_pass(ctrl_r.sha_chk, fields.sender_hw_addr == fields.frame_source_mac);
  assign tha_ok = tri_pass(ctrl_r.tha_chk, fields.target_hw_addr == fields.frame_source_mac);

  // length and address space checks
  assign len_ok = tri_pass(ctrl_r.len_chk, fields.hw_addr_len_field == HLN_ETHERNET
                           && fields.proto_addr_len_field == PLN_IPV4);
  assign hrd_ok = tri_pass(ctrl_r.hrd_chk, fields.hw_addr_space_field == HRD_ETHERNET);
  assign pro_ok = tri_pass(ctrl_r.pro_chk, fields.proto_addr_space_field == PRO_IP);

  // combinational result so the action logic sees it with the fields
  assign all_ok = kind_ok && dir_ok && sip_ok && tip_ok && sha_ok && tha_ok && len_ok && hrd_ok && pro_ok;
  assign arp_match = !ctrl_r.type_is_arp || all_ok;
  assign entry_hit = fields.valid && arp_match;
  assign frame_drop = entry_hit && ctrl_r.deny;

  // hit counter saturates rather than wrapping; any write to it clears
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      hit_cnt_r <= '0;
    end
    else if (wr_take && avs_address == OFS_HIT_CNT)
    begin
      hit_cnt_r <= '0;
    end
    else if (entry_hit && !(&hit_cnt_r))
    begin
      hit_cnt_r <= hit_cnt_r + 1'b1;
    end
  end

  // last verdict, held until the next valid frame
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      last_hit_r <= 1'b0;
      last_drop_r <= 1'b0;
    end
    else if (fields.valid)
    begin
      last_hit_r <= entry_hit;
      last_drop_r <= frame_drop;
    end
  end

  // read data captured on the first cycle; unmapped reads as zero
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      avs_readdata <= 32'h0000_0000;
    end
    else if (avs_read && !ack_r)
    begin
      case (avs_address)
        OFS_CTRL: avs_readdata <= ctrl_r;
        OFS_SIP_ADDR: avs_readdata <= sip_addr_r;
        OFS_SENDER_PROTO_MASK_CFG: avs_readdata <= sender_proto_mask_cfg_r;
        OFS_TIP_ADDR: avs_readdata <= tip_addr_r;
        OFS_TIP_MASK: avs_readdata <= tip_mask_r;
        OFS_STATUS: avs_readdata <= {30'h0000_0000, last_drop_r, last_hit_r};
        OFS_HIT_CNT: avs_readdata <= 32'(hit_cnt_r);
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // checks next to the logic
  a_drop_needs_deny: assert property (@(posedge core_clk) disable iff (rst)
    frame_drop |-> entry_hit && ctrl_r.deny && fields.valid)
    else $error("drop without a hit on a deny entry");

  a_non_arp_passes: assert property (@(posedge core_clk) disable iff (rst)
    fields.valid && !ctrl_r.type_is_arp |-> entry_hit)
    else $error("non-ARP entry blocked by ARP criteria");

  a_host_sip_exact: assert property (@(posedge core_clk) disable iff (rst)
    ctrl_r.type_is_arp && ctrl_r.sip_mode == ADDR_HOST && fields.sender_proto_addr != sip_addr_r |-> !arp_match)
    else $error("sender host mismatch still matched");

  a_net_tip_masked: assert property (@(posedge core_clk) disable iff (rst)
    ctrl_r.type_is_arp && ctrl_r.tip_mode == ADDR_NET
    && ((fields.target_proto_addr ^ tip_addr_r) & tip_mask_r) != 32'h0000_0000 |-> !arp_match)
    else $error("target network mismatch still matched");

  a_other_kind_only: assert property (@(posedge core_clk) disable iff (rst)
    ctrl_r.type_is_arp && ctrl_r.kind_sel == KIND_OTHER && (is_arp_op || is_rarp_op) |-> !arp_match)
    else $error("known opcode matched the other setting");

  a_reply_dir_only: assert property (@(posedge core_clk) disable iff (rst)
    ctrl_r.type_is_arp && ctrl_r.dir_sel == DIR_REPLY && is_req_op |-> !arp_match)
    else $error("request matched a reply entry");

  a_len_one_exact: assert property (@(posedge core_clk) disable iff (rst)
    ctrl_r.type_is_arp && ctrl_r.len_chk == TRI_ONE && fields.hw_addr_len_field != HLN_ETHERNET |-> !arp_match)
    else $error("bad hardware length matched");

  a_hrd_zero_unequal: assert property (@(posedge core_clk) disable iff (rst)
    ctrl_r.type_is_arp && ctrl_r.hrd_chk == TRI_ZERO && fields.hw_addr_space_field == HRD_ETHERNET |-> !arp_match)
    else $error("ethernet hardware type matched setting zero");

  a_sha_one_equal: assert property (@(posedge core_clk) disable iff (rst)
    ctrl_r.type_is_arp && ctrl_r.sha_chk == TRI_ONE && fields.sender_hw_addr != fields.frame_source_mac
    |-> !arp_match)
    else $error("sender hw differs yet matched");

  a_hit_counts_up: assert property (@(posedge core_clk) disable iff (rst)
    entry_hit && !(&hit_cnt_r) && !wr_take |=> hit_cnt_r == $past(hit_cnt_r) + 1'b1)
    else $error("hit not counted");

  a_bus_one_wait: assert property (@(posedge core_clk) disable iff (rst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held over one cycle");

endmodule // arp_acl_field_matcher
`default_nettype wire

// >>> rtl/arp_acl_pkg.sv
// Behaviour
// - ARP criteria apply only when the entry frame type selects ARP.
// - Opcode kind: any, ARP-only or RARP-only; frame opcode must be of that kind.
// - Opcode kind fourth setting matches only opcodes neither ARP nor RARP.
// - Direction: any, request (ARP/RARP request) or reply (ARP/RARP reply).
// - Sender address filter don't-care ignores the sender protocol address.
// - Sender host mode needs exact equality with the configured sender address.
// - Sender network mode compares only bits set in the sender mask.
// - Target address filter don't-care ignores the target protocol address.
// - Target host mode needs exact equality with the configured target address.
// - Target network mode compares only bits set in the target mask.
// - Sender hw check: 0 needs differs from source MAC, 1 equal, else don't-care.
// - Target hw check: 0 needs differs from source MAC, 1 equal, else don't-care.
// - Length check 1 needs hw length 0x06 and protocol length 0x04.
// - Hw space check 1 needs hardware type equal to Ethernet, 1.
// - Every three-way check has a don't-care setting that always passes.
// - All criteria passing is a hit; a hit on a deny entry drops the frame.
`default_nettype none
package arp_acl_pkg;
  // register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_SIP_ADDR = 5'h04;
  localparam logic [4:0] OFS_SENDER_PROTO_MASK_CFG = 5'h08;
  localparam logic [4:0] OFS_TIP_ADDR = 5'h0C;
  localparam logic [4:0] OFS_TIP_MASK = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;
  localparam logic [4:0] OFS_HIT_CNT = 5'h18;
  // opcode and header field values
  localparam logic [15:0] OPC_ARP_REQ = 16'h0001;
  localparam logic [15:0] OPC_ARP_REPLY = 16'h0002;
  localparam logic [15:0] OPC_RARP_REQ = 16'h0003;
  localparam logic [15:0] OPC_RARP_REPLY = 16'h0004;
  localparam logic [7:0] HLN_ETHERNET = 8'h06;
  localparam logic [7:0] PLN_IPV4 = 8'h04;
  localparam logic [15:0] HRD_ETHERNET = 16'h0001;
  localparam logic [15:0] PRO_IP = 16'h0800;
  // setting encodings
  localparam logic [1:0] TRI_ZERO = 2'h0;
  localparam logic [1:0] TRI_ONE = 2'h1;
  localparam logic [1:0] TRI_ANY = 2'h2;
  localparam logic [1:0] KIND_ANY = 2'h0;
  localparam logic [1:0] KIND_ARP = 2'h1;
  localparam logic [1:0] KIND_RARP = 2'h2;
  localparam logic [1:0] KIND_OTHER = 2'h3;
  localparam logic [1:0] DIR_ANY = 2'h0;
  localparam logic [1:0] DIR_REQ = 2'h1;
  localparam logic [1:0] DIR_REPLY = 2'h2;
  localparam logic [1:0] ADDR_ANY = 2'h0;
  localparam logic [1:0] ADDR_HOST = 2'h1;
  localparam logic [1:0] ADDR_NET = 2'h2;

  // entry configuration, laid out as the control word
  typedef struct packed {
    logic [11:0] spare;
    logic [1:0] pro_chk;
    logic [1:0] hrd_chk;
    logic [1:0] len_chk;
    logic [1:0] tha_chk;
    logic [1:0] sha_chk;
    logic [1:0] tip_mode;
    logic [1:0] sip_mode;
    logic [1:0] dir_sel;
    logic [1:0] kind_sel;
    logic deny;
    logic type_is_arp;
  } entry_cfg_t;
  localparam entry_cfg_t CTRL_RESET = '{spare: 12'h000, pro_chk: TRI_ANY, hrd_chk: TRI_ANY,
    len_chk: TRI_ANY, tha_chk: TRI_ANY, sha_chk: TRI_ANY, tip_mode: ADDR_ANY, sip_mode: ADDR_ANY,
    dir_sel: DIR_ANY, kind_sel: KIND_ANY, deny: 1'b0, type_is_arp: 1'b0};

  // parsed fields from the ingress parser
  typedef struct packed {
    logic valid;
    logic [47:0] frame_source_mac;
    logic [15:0] hw_addr_space_field;
    logic [15:0] proto_addr_space_field;
    logic [7:0] hw_addr_len_field;
    logic [7:0] proto_addr_len_field;
    logic [15:0] arp_opcode_field;
    logic [47:0] sender_hw_addr;
    logic [31:0] sender_proto_addr;
    logic [47:0] target_hw_addr;
    logic [31:0] target_proto_addr;
  } arp_fields_t;
endpackage
`default_nettype wire

// >>> verification/arp_frame_src.sv
`default_nettype none
module arp_frame_src
  import arp_acl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic send,
  input wire arp_fields_t frame_in,
  output var arp_fields_t fields
);
  timeunit 1ns;
  timeprecision 1ns;

  // one valid cycle per send; between frames valid stays low and every other field flips so stale data never matches by luck
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      fields <= '0;
    else if (send)
      fields <= frame_in;
    else
      fields <= {1'b0, ~fields[$bits(arp_fields_t)-2:0]};
  end
endmodule // arp_frame_src
`default_nettype wire

// >>> verification/arp_acl_field_matcher_tb.sv
`default_nettype none
module arp_acl_field_matcher_tb
  import arp_acl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rst, avs_read, avs_write, avs_waitrequest, arp_match, entry_hit, frame_drop, send;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, sa, sm, ta, tm;
  logic [3:0] avs_byteenable;
  arp_fields_t fields, frame_in, g, f;
  entry_cfg_t c;
  int miscompares, checks;

  arp_acl_field_matcher #(.CNT_W(4)) uut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fields(fields), .arp_match(arp_match), .entry_hit(entry_hit), .frame_drop(frame_drop));
  arp_frame_src src (.core_clk(core_clk), .rst(rst), .send(send), .frame_in(frame_in), .fields(fields));

  // 10 MHz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // one access, held until waitrequest is sampled low at a rising edge; bounded wait
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge core_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      miscompares++;
      end_of_test();
    end
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    chk("readdata", rd, e);
  endtask

  function automatic logic tri3(input logic [1:0] s, input logic e);
    return s == 2'h0 ? !e : s == 2'h1 ? e : 1'b1;
  endfunction

  function automatic logic amatch(input logic [1:0] m, input logic [31:0] v, a, k);
    return m == 2'h1 ? v == a : m == 2'h2 ? ((v ^ a) & k) == 32'h0 : 1'b1;
  endfunction

  // bench's own expectation of the ARP part, worked out field by field
  function automatic logic model(input entry_cfg_t k, input arp_fields_t x);
    logic [15:0] op;
    logic a, r, ok;
    op = x.arp_opcode_field;
    a = op == 16'h0001 || op == 16'h0002;
    r = op == 16'h0003 || op == 16'h0004;
    ok = k.kind_sel == 2'h1 ? a : k.kind_sel == 2'h2 ? r : k.kind_sel == 2'h3 ? !a && !r : 1'b1;
    ok &= k.dir_sel == 2'h1 ? op == 16'h0001 || op == 16'h0003 :
      k.dir_sel == 2'h2 ? op == 16'h0002 || op == 16'h0004 : 1'b1;
    ok &= amatch(k.sip_mode, x.sender_proto_addr, sa, sm) & amatch(k.tip_mode, x.target_proto_addr, ta, tm);
    ok &= tri3(k.sha_chk, x.sender_hw_addr == x.frame_source_mac);
    ok &= tri3(k.tha_chk, x.target_hw_addr == x.frame_source_mac);
    ok &= tri3(k.len_chk, x.hw_addr_len_field == 8'h06 && x.proto_addr_len_field == 8'h04);
    ok &= tri3(k.hrd_chk, x.hw_addr_space_field == 16'h0001) & tri3(k.pro_chk, x.proto_addr_space_field == 16'h0800);
    return !k.type_is_arp || ok;
  endfunction

  // results are combinational, so they are looked at mid-cycle while the frame stands
  task automatic frame(input arp_fields_t x);
    logic e;
    e = model(c, x);
    @(posedge core_clk);
    send <= 1'b1;
    frame_in <= x;
    @(posedge core_clk);
    send <= 1'b0;
    @(negedge core_clk);
    chk("arp_match", 32'(arp_match), 32'(e));
    chk("entry_hit", 32'(entry_hit), 32'(e));
    chk("frame_drop", 32'(frame_drop), 32'(e & c.deny));
  endtask

  // main sequence
  initial
  begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    send = 1'b0;
    frame_in = '0;
    c = 32'h000AA800;
    sa = 32'hC0A80105;
    sm = 32'hFFFFFF00;
    ta = 32'h0A000001;
    tm = 32'hFF000000;
    g = '{1'b1, 48'h001122334455, 16'h0001, 16'h0800, 8'h06, 8'h04, 16'h0001,
      48'h001122334455, sa, 48'h001122334455, ta};
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rchk(OFS_CTRL, 32'h000AA800);
    for (int i = 4; i <= 28; i += 4)
      rchk(5'(i), 32'h0);
    bus(1'b1, OFS_STATUS, 32'hFFFFFFFF, 4'hF);
    rchk(OFS_STATUS, 32'h0);
    bus(1'b1, OFS_SIP_ADDR, 32'hFFFFFFFF, 4'h2);
    rchk(OFS_SIP_ADDR, 32'h0000FF00);
    bus(1'b1, OFS_SIP_ADDR, sa, 4'hF);
    bus(1'b1, OFS_SENDER_PROTO_MASK_CFG, sm, 4'hF);
    bus(1'b1, OFS_TIP_ADDR, ta, 4'hF);
    bus(1'b1, OFS_TIP_MASK, tm, 4'hF);
    f = g;
    f.arp_opcode_field = 16'h0009;
    f.hw_addr_len_field = 8'h00;
    frame(f);
    c.type_is_arp = 1'b1;
    // every opcode kind and direction against opcodes 0..5
    for (int k = 0; k < 16; k++)
    begin
      c.kind_sel = 2'(k);
      c.dir_sel = 2'(k >> 2);
      bus(1'b1, OFS_CTRL, c, 4'hF);
      for (int o = 0; o < 6; o++)
      begin
        f = g;
        f.arp_opcode_field = 16'(o);
        frame(f);
      end
    end
    c.kind_sel = 2'h0;
    c.dir_sel = 2'h0;
    // one bit flipped outside, then inside, each mask
    for (int m = 0; m < 4; m++)
    begin
      c.sip_mode = 2'(m);
      c.tip_mode = 2'(m);
      bus(1'b1, OFS_CTRL, c, 4'hF);
      for (int v = 0; v < 5; v++)
      begin
        f = g;
        f.sender_proto_addr = sa ^ (v == 1 ? 32'h1 : v == 2 ? 32'h100 : 32'h0);
        f.target_proto_addr = ta ^ (v == 3 ? 32'h1 : v == 4 ? 32'h01000000 : 32'h0);
        frame(f);
      end
    end
    // each three-way check alone, at every setting, on good and broken frames
    for (int j = 0; j < 5; j++)
      for (int s = 0; s < 4; s++)
      begin
        c = 32'h000AA801;
        c[10 + 2 * j +: 2] = 2'(s);
        bus(1'b1, OFS_CTRL, c, 4'hF);
        for (int b = 0; b < 3; b++)
        begin
          f = g;
          if (b != 0)
          begin
            if (j == 0) f.sender_hw_addr[0] = 1'b0;
            if (j == 1) f.target_hw_addr[47] = 1'b1;
            if (j == 2 && b == 1) f.hw_addr_len_field = 8'h07;
            if (j == 2 && b == 2) f.proto_addr_len_field = 8'h05;
            if (j == 3) f.hw_addr_space_field = 16'h0006;
            if (j == 4) f.proto_addr_space_field = 16'h86DD;
          end
          frame(f);
        end
      end
    // deny entry, status and a 4-bit counter that saturates
    c = 32'h000AA803;
    bus(1'b1, OFS_CTRL, c, 4'hF);
    bus(1'b1, OFS_HIT_CNT, 32'h0, 4'hF);
    repeat (3) frame(g);
    rchk(OFS_STATUS, 32'h3);
    rchk(OFS_HIT_CNT, 32'h3);
    repeat (14) frame(g);
    rchk(OFS_HIT_CNT, 32'hF);
    c.kind_sel = KIND_ARP;
    bus(1'b1, OFS_CTRL, c, 4'hF);
    f = g;
    f.arp_opcode_field = 16'h0004;
    frame(f);
    rchk(OFS_STATUS, 32'h0);
    end_of_test();
  end
endmodule // arp_acl_field_matcher_tb
`default_nettype wire
